// ---- common/pfwc_defs.svh ----
// Purpose: constants for the pin function and wake control block
// Assumes: included by its bare name from the design; the package does not include it
// Notes: field positions and reset values only
`ifndef PFWC_DEFS_SVH
`define PFWC_DEFS_SVH

// port c function config bit positions
`define PFWC_CFG_WR_BIT 0
`define PFWC_CFG_RD_BIT 1
// port c function config reset value: both pins general purpose
`define PFWC_CFG_RESET 2'h0

// cpu control status bit positions
`define PFWC_CS_CLKEN_BIT 0
`define PFWC_CS_SPEED_BIT 1
// clock output enable reset value
`define PFWC_CLKEN_RESET 1'h1

`endif

// ---- common/pfwc_pkg.sv ----
// Purpose: types for the pin function and wake control block
// Assumes: pfwc_defs.svh holds the numbers
// Notes: pin groups travel as packed structs
package pfwc_pkg;
	// suspend state of the processor clocking
	typedef enum logic [0:0] {
		PFWC_RUN,
		PFWC_SUSP
	} pfwc_mode_e;

	// one driven pin: level and active-low output enable
	typedef struct packed {
		logic o;
		logic oe_n;
	} pfwc_pin_s;

	// general purpose latch and enable for port c bits 6 and 7
	typedef struct packed {
		logic [1:0] latch;
		logic [1:0] oe;
	} pfwc_gpio_s;

	// all state of the block
	typedef struct packed {
		pfwc_mode_e mode;
		logic [1:0] sel;
		logic clk_en;
		logic speed12;
		logic div;
		logic pll_prev;
		logic wake_prev;
		logic wake_irq;
		logic osc_run;
		pfwc_pin_s pc6;
		pfwc_pin_s pc7;
		pfwc_pin_s clk;
		logic [1:0] pin_state;
	} pfwc_state_s;
endpackage

// ---- src/pfwc_top.sv ----
// Purpose: port c strobe muxing, clock output, speed strap and wake control
// Assumes: all inputs synchronous to MCLK; PLL_CLOCK_OUTPUT is the 24 MHz pll output
// Notes: every output is registered; pins follow direct inputs by one cycle, register writes and the 12 MHz divider by two
// Functional notes
// (R1) bit6 is gpio or write strobe
// (R2) bit7 is gpio or read strobe
// (R3) clock output carries pll 24 MHz clock
// (R4) 12 MHz mode halves the clock output
// (R5) clock output enable bit gates the pin
// (R6) wake falling edge in suspend resumes processor
// (R7) low wake input blocks suspend entry
// (R8) speed strap selects 12 or 24 MHz
// (R9) board test floats every functional pin
// (R10) board pulls both strobes up externally
// (R11) reset leaves bit6 and bit7 as inputs
`timescale 1ns/10ps
`default_nettype none
`include "pfwc_defs.svh"

module pfwc_top (
	// clock and reset
	input wire logic MCLK,
	input wire logic RESET,
	// clock sources and straps
	input wire logic PLL_CLOCK_OUTPUT,
	input wire logic CPU_SPEED_STRAP,
	input wire logic BOARD_TEST,
	// port c function config write
	input wire logic PORT_C_FUNCTION_CONFIG_WE,
	input wire logic [1:0] PORT_C_FUNCTION_CONFIG_DATA,
	// cpu control status write and readback
	input wire logic CPU_CONTROL_STATUS_WE,
	input wire logic [1:0] CPU_CONTROL_STATUS_DATA,
	output wire logic [1:0] CPU_CONTROL_STATUS_RD,
	// processor side strobes and gpio
	input wire logic EXT_WR_N,
	input wire logic EXT_RD_N,
	input wire pfwc_pkg::pfwc_gpio_s GPIO,
	output wire logic [1:0] PORT_C_PIN_STATE,
	// port c pins
	input wire logic PORT_C_BIT6_IN,
	output wire pfwc_pkg::pfwc_pin_s PORT_C_BIT6,
	input wire logic PORT_C_BIT7_IN,
	output wire pfwc_pkg::pfwc_pin_s PORT_C_BIT7,
	// clock output pin
	output wire pfwc_pkg::pfwc_pin_s CLOCK_OUTPUT,
	// suspend and wake
	input wire logic SUSPEND_REQ,
	input wire logic WAKEUP_N,
	output wire logic OSC_RUN,
	output wire logic WAKE_IRQ,
	output wire logic SUSPENDED
);
	import pfwc_pkg::*;

	pfwc_state_s s_q; // registered state
	pfwc_state_s s_d; // next state

	// pick a port c pin's source: strobe when selected, else the gpio latch
	function automatic pfwc_pin_s pin_mux(input logic sel, input logic strobe,
			input logic latch, input logic oe, input logic test);
		pfwc_pin_s p;
		p.o = sel ? strobe : latch;
		p.oe_n = sel ? 1'b0 : ~oe;
		// board test overrides any drive
		if (test) begin
			p.oe_n = 1'b1;
		end
		return p;
	endfunction

	// next state
	always_comb begin
		s_d = s_q;
		s_d.wake_prev = WAKEUP_N;
		s_d.pll_prev = PLL_CLOCK_OUTPUT;
		s_d.wake_irq = 1'b0;
		// divide the pll clock by two on its rising edge, keeping phase lock
		if (PLL_CLOCK_OUTPUT && !s_q.pll_prev) begin
			s_d.div = ~s_q.div; // [R4]
		end
		// port c function select write
		if (PORT_C_FUNCTION_CONFIG_WE) begin
			s_d.sel = PORT_C_FUNCTION_CONFIG_DATA;
		end
		// clock output enable write; speed bit is read only
		if (CPU_CONTROL_STATUS_WE) begin
			s_d.clk_en = CPU_CONTROL_STATUS_DATA[`PFWC_CS_CLKEN_BIT];
		end
		// suspend and wake sequencing
		unique case (s_q.mode)
			PFWC_RUN: begin
				// a low wake input keeps the device awake
				if (SUSPEND_REQ && WAKEUP_N) begin
					s_d.mode = PFWC_SUSP; // [R7]
					s_d.osc_run = 1'b0;
				end
			end
			PFWC_SUSP: begin
				// falling edge restarts oscillator and interrupts the processor
				if (s_q.wake_prev && !WAKEUP_N) begin
					s_d.mode = PFWC_RUN; // [R6]
					s_d.osc_run = 1'b1;
					s_d.wake_irq = 1'b1;
				end
			end
		endcase
		// port c pins; strobes rely on board pull-ups while floated
		s_d.pc6 = pin_mux(s_q.sel[`PFWC_CFG_WR_BIT], EXT_WR_N, GPIO.latch[0],
			GPIO.oe[0], BOARD_TEST); // [R1] [R9] [R10]
		s_d.pc7 = pin_mux(s_q.sel[`PFWC_CFG_RD_BIT], EXT_RD_N, GPIO.latch[1],
			GPIO.oe[1], BOARD_TEST); // [R2] [R9] [R10]
		// clock output: pll clock, or its half in 12 MHz mode
		s_d.clk.o = s_q.speed12 ? s_q.div : PLL_CLOCK_OUTPUT; // [R3] [R4]
		s_d.clk.oe_n = ~s_q.clk_en | BOARD_TEST; // [R5] [R9]
		s_d.pin_state = {PORT_C_BIT7_IN, PORT_C_BIT6_IN};
		// synchronous reset; the strap is caught here
		if (RESET) begin
			s_d.mode = PFWC_RUN;
			s_d.sel = `PFWC_CFG_RESET; // [R11]
			s_d.clk_en = `PFWC_CLKEN_RESET;
			s_d.speed12 = CPU_SPEED_STRAP; // [R8]
			s_d.div = 1'b0;
			s_d.pll_prev = 1'b0;
			s_d.wake_prev = 1'b1;
			s_d.wake_irq = 1'b0;
			s_d.osc_run = 1'b1;
			s_d.pc6 = '{o: 1'b1, oe_n: 1'b1}; // [R11]
			s_d.pc7 = '{o: 1'b1, oe_n: 1'b1}; // [R11]
			s_d.clk = '{o: 1'b0, oe_n: 1'b1};
			s_d.pin_state = 2'h0;
		end
	end

	// state register
	always_ff @(posedge MCLK) begin
		s_q <= s_d;
	end

	// outputs straight from flops
	assign PORT_C_BIT6 = s_q.pc6;
	assign PORT_C_BIT7 = s_q.pc7;
	assign CLOCK_OUTPUT = s_q.clk;
	assign PORT_C_PIN_STATE = s_q.pin_state;
	assign CPU_CONTROL_STATUS_RD = {s_q.speed12, s_q.clk_en};
	assign OSC_RUN = s_q.osc_run;
	assign WAKE_IRQ = s_q.wake_irq;
	assign SUSPENDED = (s_q.mode == PFWC_SUSP);

	// checks
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RESET);

	// falling wake edge seen while suspended
	sequence wake_fall_s;
		s_q.mode == PFWC_SUSP && s_q.wake_prev && !WAKEUP_N;
	endsequence
	// one-cycle interrupt with oscillator running
	sequence wake_answer_s;
		WAKE_IRQ && OSC_RUN && !SUSPENDED ##1 !WAKE_IRQ;
	endsequence

	a_wr_strobe_mux: assert property ( // [R1]
		s_q.sel[0] && !BOARD_TEST |=> !PORT_C_BIT6.oe_n && PORT_C_BIT6.o == $past(EXT_WR_N))
		else $error("write strobe not on bit6");
	a_rd_strobe_mux: assert property ( // [R2]
		s_q.sel[1] && !BOARD_TEST |=> !PORT_C_BIT7.oe_n && PORT_C_BIT7.o == $past(EXT_RD_N))
		else $error("read strobe not on bit7");
	a_gpio_bit6_mux: assert property ( // [R1]
		!s_q.sel[0] && !BOARD_TEST |=> PORT_C_BIT6.o == $past(GPIO.latch[0])
			&& PORT_C_BIT6.oe_n == !$past(GPIO.oe[0]))
		else $error("bit6 gpio path wrong");
	a_clk_full_rate: assert property ( // [R3]
		!s_q.speed12 |=> CLOCK_OUTPUT.o == $past(PLL_CLOCK_OUTPUT))
		else $error("clock output not following pll");
	a_clk_half_rate: assert property ( // [R4]
		s_q.speed12 && PLL_CLOCK_OUTPUT && !s_q.pll_prev |=> ##1 CLOCK_OUTPUT.o != $past(CLOCK_OUTPUT.o))
		else $error("half rate clock did not toggle");
	a_clk_gate_off: assert property ( // [R5]
		!s_q.clk_en || BOARD_TEST |=> CLOCK_OUTPUT.oe_n)
		else $error("clock output driven while disabled");
	a_clk_gate_on: assert property ( // [R5]
		s_q.clk_en && !BOARD_TEST |=> !CLOCK_OUTPUT.oe_n)
		else $error("clock output floated while enabled");
	a_wake_resume: assert property ( // [R6]
		wake_fall_s |=> wake_answer_s)
		else $error("wake edge did not resume");
	a_wake_holds_off: assert property ( // [R7]
		!SUSPENDED && !WAKEUP_N |=> !SUSPENDED)
		else $error("suspended while wake held low");
	a_strap_speed: assert property ( // [R8]
		$past(RESET) |-> CPU_CONTROL_STATUS_RD[1] == $past(CPU_SPEED_STRAP))
		else $error("speed strap not captured");
	a_test_float: assert property ( // [R9]
		BOARD_TEST |=> PORT_C_BIT6.oe_n && PORT_C_BIT7.oe_n && CLOCK_OUTPUT.oe_n)
		else $error("pin driven during board test");
	a_reset_inputs: assert property ( // [R11]
		$past(RESET) |-> s_q.sel == 2'h0 && PORT_C_BIT6.oe_n && PORT_C_BIT7.oe_n)
		else $error("port c not inputs after reset");
	// bit7 follows its latch and enable as general purpose i/o
	a_gpio_bit7_mux: assert property ( // [R2]
		!s_q.sel[1] && !BOARD_TEST |=> PORT_C_BIT7.o == $past(GPIO.latch[1])
			&& PORT_C_BIT7.oe_n == !$past(GPIO.oe[1]))
		else $error("bit7 gpio path wrong");
	// a config write lands in the select bits on the next edge
	a_cfg_write: assert property ( // [R1] [R2]
		PORT_C_FUNCTION_CONFIG_WE |=> s_q.sel == $past(PORT_C_FUNCTION_CONFIG_DATA))
		else $error("function select write lost");
	// enable write shows in the readback one edge later
	a_clken_write: assert property ( // [R5]
		CPU_CONTROL_STATUS_WE |=> CPU_CONTROL_STATUS_RD[`PFWC_CS_CLKEN_BIT]
			== $past(CPU_CONTROL_STATUS_DATA[`PFWC_CS_CLKEN_BIT]))
		else $error("clock enable write lost");
	// the speed bit is read only; only reset reloads it
	a_speed_hold: assert property ( // [R8]
		CPU_CONTROL_STATUS_WE |=> $stable(CPU_CONTROL_STATUS_RD[`PFWC_CS_SPEED_BIT]))
		else $error("speed bit changed by a write");
	// suspend is entered one edge after an unblocked request
	a_suspend_entry: assert property ( // [R7]
		!SUSPENDED && SUSPEND_REQ && WAKEUP_N |=> SUSPENDED && !OSC_RUN)
		else $error("suspend request not taken");
	// no resume interrupt without a wake edge in suspend
	a_irq_cause: assert property ( // [R6]
		WAKE_IRQ |-> $past(SUSPENDED) && !$past(WAKEUP_N))
		else $error("resume interrupt without wake edge");
	// suspend holds while the wake input stays high
	a_suspend_stays: assert property ( // [R6]
		SUSPENDED && WAKEUP_N |=> SUSPENDED)
		else $error("left suspend without wake edge");
endmodule
`default_nettype wire

// ---- verif/pfwc_board_model.sv ----
// Purpose: board side of port c bits 6 and 7
// Assumes: strobe lines carry pull-ups on the board
// Notes: a released pin reads as the pull-up level
`timescale 1ns/10ps
`default_nettype none
module pfwc_board_model (
	// driven pins from the block
	input wire pfwc_pkg::pfwc_pin_s PIN6,
	input wire pfwc_pkg::pfwc_pin_s PIN7,
	// resolved wire levels
	output logic LVL6,
	output logic LVL7
);
	import pfwc_pkg::*;
	// released pin floats up through its resistor
	assign LVL6 = PIN6.oe_n ? 1'b1 : PIN6.o;
	assign LVL7 = PIN7.oe_n ? 1'b1 : PIN7.o;
endmodule
`default_nettype wire

// ---- verif/test_pfwc_top.sv ----
// Purpose: self-checking bench for the pin function and wake block
// Assumes: outputs registered, answers within a few cycles
// Notes: pll clock made by hand, four MCLK cycles a period
`timescale 1ns/10ps
`default_nettype none
module test_pfwc_top;
	import pfwc_pkg::*;
	logic mclk, rst = 1'b1, pll = 1'b0, strap = 1'b0, tst = 1'b0;
	logic cfg_we = 1'b0, cs_we = 1'b0, wr_n = 1'b1, rd_n = 1'b1, susp = 1'b0, wake_n = 1'b1;
	logic [1:0] cfg_d = 2'h0, cs_d = 2'h1, cs_rd, pst;
	pfwc_gpio_s gpio = '0;
	pfwc_pin_s p6, p7, ck;
	wire logic l6, l7, osc, irq, sus;
	int bad_count = 0, n_compared = 0, cyc = 0, rises = 0;
	logic ck_prev = 1'b0;
	// design and board
	pfwc_top i_dut (.MCLK(mclk), .RESET(rst), .PLL_CLOCK_OUTPUT(pll), .CPU_SPEED_STRAP(strap),
		.BOARD_TEST(tst), .PORT_C_FUNCTION_CONFIG_WE(cfg_we),
		.PORT_C_FUNCTION_CONFIG_DATA(cfg_d), .CPU_CONTROL_STATUS_WE(cs_we),
		.CPU_CONTROL_STATUS_DATA(cs_d), .CPU_CONTROL_STATUS_RD(cs_rd), .EXT_WR_N(wr_n),
		.EXT_RD_N(rd_n), .GPIO(gpio), .PORT_C_PIN_STATE(pst), .PORT_C_BIT6_IN(l6),
		.PORT_C_BIT6(p6), .PORT_C_BIT7_IN(l7), .PORT_C_BIT7(p7), .CLOCK_OUTPUT(ck),
		.SUSPEND_REQ(susp), .WAKEUP_N(wake_n), .OSC_RUN(osc), .WAKE_IRQ(irq),
		.SUSPENDED(sus));
	pfwc_board_model i_board (.PIN6(p6), .PIN7(p7), .LVL6(l6), .LVL7(l7));
	// 200 MHz clock
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// hang guard and clock output edge counter
	always @(posedge mclk) begin
		cyc++;
		ck_prev <= ck.o;
		if (ck.o === 1'b1 && ck_prev === 1'b0) rises++;
		if (cyc == 3000) begin
			bad_count++;
			finish_test();
		end
	end
	// inputs change by nba on the edge; outputs read here still hold the last edge's values
	task step(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// reset with a given strap, then reset values
	task t_reset(input logic s);
		rst <= 1'b1;
		strap <= s;
		step(8);
		rst <= 1'b0;
		chk(8'({p6, p7, ck, cs_rd}), 8'({4'hF, 2'h1, s, 1'b1}));
		chk(8'({osc, irq, sus}), 8'h4);
	endtask
	// strobe selection and gpio fallback
	task t_strobe;
		cfg_we <= 1'b1;
		cfg_d <= 2'h3;
		wr_n <= 1'b0;
		gpio <= '{latch: 2'h1, oe: 2'h1};
		step(1);
		cfg_we <= 1'b0;
		step(3);
		chk(8'({p6, p7, pst}), 8'({2'h0, 2'h2, 2'h2}));
		// swap strobe levels so each pin must follow its own strobe
		wr_n <= 1'b1;
		rd_n <= 1'b0;
		step(3);
		chk(8'({p6, p7, pst}), 8'({2'h2, 2'h0, 2'h1}));
		cfg_we <= 1'b1;
		cfg_d <= 2'h0;
		wr_n <= 1'b0;
		rd_n <= 1'b1;
		step(1);
		cfg_we <= 1'b0;
		step(3);
		chk(8'({p6, p7.oe_n, pst}), 8'({2'h2, 1'b1, 2'h3}));
		// drive bit7 low from its latch while the read strobe idles high
		gpio <= '{latch: 2'h1, oe: 2'h3};
		step(3);
		chk(8'({p6, p7, pst}), 8'({2'h2, 2'h0, 2'h1}));
		wr_n <= 1'b1;
		gpio <= '0;
	endtask
	// count clock output edges over eight pll periods
	task t_clk(input logic s, input int exp);
		t_reset(s);
		step(4);
		rises = 0;
		repeat (8) begin
			pll <= 1'b1;
			step(2);
			pll <= 1'b0;
			step(2);
		end
		step(4);
		chk(8'(rises), 8'(exp));
		chk(8'(ck.oe_n), 8'h0);
	endtask
	// clock enable off then on
	task t_clken(input logic en);
		cs_we <= 1'b1;
		cs_d <= {1'b0, en};
		step(1);
		cs_we <= 1'b0;
		step(3);
		chk(8'({ck.oe_n, cs_rd}), 8'({~en, 1'b1, en}));
	endtask
	// suspend blocked, suspend taken, wake edge
	task t_wake;
		int n;
		wake_n <= 1'b0;
		susp <= 1'b1;
		step(3);
		chk(8'({sus, osc}), 8'h1);
		wake_n <= 1'b1;
		step(2);
		susp <= 1'b0;
		chk(8'({sus, osc}), 8'h2);
		wake_n <= 1'b0;
		n = 0;
		repeat (6) begin
			step(1);
			if (irq === 1'b1) n++;
		end
		chk(8'({n[3:0], sus, osc}), 8'h5);
		wake_n <= 1'b1;
	endtask
	// board test floats every pin
	task t_float;
		tst <= 1'b1;
		step(2);
		chk(8'({p6.oe_n, p7.oe_n, ck.oe_n}), 8'h7);
		tst <= 1'b0;
	endtask
	task finish_test;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		t_reset(1'b0);
		t_strobe();
		t_clk(1'b0, 8);
		t_clk(1'b1, 4);
		t_clken(1'b0);
		t_clken(1'b1);
		t_wake();
		t_float();
		finish_test();
	end
endmodule
`default_nettype wire
